// file: src/dbg_select_consts.svh
// Constants for the debug port select and hold unit.
// Assumes inclusion by bare name from the package, the top module and the testbench.
`ifndef DBG_SELECT_CONSTS_SVH
`define DBG_SELECT_CONSTS_SVH
`define ADDR_ID_CODE        12'h000
`define ADDR_DEBUG_CONTROL  12'h004
`define DEBUG_CONTROL_RESET 32'h0000_0000
`define DEBUG_CONTROL_MASK  32'h7E1F_BF27
`define ID_CODE_VALUE       32'h1234_5678 // Arbitrary value
`define BSCAN_IDCODE        32'h0ABC_DEF1 // Arbitrary value, LSB one as the TAP wants
`define TO_SWD_CODE         16'hE79E
`define TO_JTAG_CODE        16'hE73C
`define HIGH_RUN_MIN        7'd50
`define ROM_BASE            32'hE00F_F000
`define ROM_LAST            32'hE00F_FFFF
`define BIT_SLP_KEEP        0
`define BIT_DSLP_KEEP       1
`define BIT_STB_KEEP        2
`define BIT_TRACE_EN        5
`define BIT_FWDG_FREEZE     8
`define BIT_WWDG_FREEZE     9
`define BIT_I2C0_FREEZE     15
`define BIT_I2C1_FREEZE     16
`define BSCAN_IR_BYPASS     5'h1F
`define BSCAN_IR_IDCODE     5'h01
`endif

// file: src/dbg_select_pkg.sv
// Types for the debug port select and hold unit.
// Assumes the constants header is on the include path.
`include "dbg_select_consts.svh"
package dbg_select_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LEAD, SEQ_CODE, SEQ_TAIL} seq_state_t;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;
  typedef struct packed {
    logic [1:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] trst_sync;
    logic       tck_prev;
  } pin_sync_t;
  typedef struct packed {
    logic        swd_mode;
    seq_state_t  seq;
    logic [6:0]  high_cnt;
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    tap_state_t  tap;
    logic [4:0]  ir_shift;
    logic [4:0]  ir;
    logic [31:0] dr_shift;
    logic        tdo;
    logic        tdo_en;
  } port_state_t;
  typedef struct packed {
    logic        halt_pending;
    logic        halt_hold;
    logic [31:0] prdata;
  } sys_state_t;
  typedef struct packed {
    logic [31:0] debug_control_reg;
  } por_state_t;
  typedef struct packed {
    logic timer_freeze;
    logic i2c_freeze;
    logic wdg_gate;
  } hold_out_t;
endpackage

// file: src/debug_port_select_and_hold.sv
// Debug port switch, boundary-scan TAP front, debug control register and hold controls.
// Assumes an APB master on CLK_SYS, probe pins asynchronous, POR_N from the power supervisor.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "dbg_select_consts.svh"
module debug_port_select_and_hold (
  // Clock, enable and resets
  input  wire logic        CLK_SYS,
  input  wire logic        CE,
  input  wire logic        RESETN,
  input  wire logic        POR_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Probe pins
  input  wire logic        TEST_CLOCK_PIN,
  input  wire logic        TEST_MODE_SELECT_PIN,
  input  wire logic        TEST_DATA_IN_PIN,
  input  wire logic        TEST_RESET_N_PIN,
  input  wire logic        TEST_RESET_USED,
  output logic             TEST_DATA_OUT_PIN,
  output logic             TEST_DATA_OUT_OE,
  input  wire logic        ASYNC_TRACE_DATA,
  // Core TAP chain and core halt
  input  wire logic        CORE_TAP_TDO,
  output logic             CORE_TAP_TDI,
  output logic             SWD_ACTIVE,
  output logic             JTAG_ACTIVE,
  output logic             SWDIO_IN,
  output logic             SWCLK_IN,
  output logic             TAP_RESET_N,
  input  wire logic        SYS_RESET_ACTIVE,
  input  wire logic        HALT_REQUEST,
  input  wire logic        CORE_HALTED,
  output logic             CORE_HALT_HOLD,
  // Pin release to general-purpose use
  output logic             RELEASE_TDI_PIN,
  output logic             RELEASE_TDO_PIN,
  output logic             RELEASE_TRST_PIN,
  // Power mode clocks
  input  wire logic        IN_SLEEP,
  input  wire logic        IN_DEEP_SLEEP,
  input  wire logic        IN_STANDBY,
  input  wire logic        STANDBY_EXIT,
  output logic             AHB_CLK_KEEP,
  output logic             SYS_CLK_FROM_RC,
  output logic             STANDBY_EXIT_RESET,
  // Hold outputs and ROM ID select
  output logic      [13:0] TIMER_FREEZE,
  output logic      [1:0]  SMBUS_TIMEOUT_FREEZE,
  output logic             WINDOW_WATCHDOG_GATE,
  output logic             FREE_WATCHDOG_GATE,
  output logic             ROM_ID_SELECT,
  input  wire logic [31:0] ROM_ADDR
);
  dbg_select_pkg::pin_sync_t   pin_q, pin_d;
  dbg_select_pkg::port_state_t port_q, port_d;
  dbg_select_pkg::sys_state_t  sys_q, sys_d;
  dbg_select_pkg::por_state_t  por_q, por_d;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic trst_n;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic halted;

  // Synchronisers: first stage feeds only the second
  always_comb
  begin
    pin_d = pin_q;
    pin_d.tck_sync  = {pin_q.tck_sync[0], TEST_CLOCK_PIN};
    pin_d.tms_sync  = {pin_q.tms_sync[0], TEST_MODE_SELECT_PIN};
    pin_d.tdi_sync  = {pin_q.tdi_sync[0], TEST_DATA_IN_PIN};
    pin_d.trst_sync = {pin_q.trst_sync[0], TEST_RESET_N_PIN};
    pin_d.tck_prev  = pin_q.tck_sync[1];
  end

  always_ff @(posedge CLK_SYS or negedge POR_N)
  begin
    if (!POR_N)
      pin_q <= '0;
    else if (CE)
      pin_q <= pin_d;
  end

  // Each test clock phase must span more than one system clock or an edge is lost
  assign tck_rise = pin_q.tck_sync[1] & ~pin_q.tck_prev;
  assign tck_fall = ~pin_q.tck_sync[1] & pin_q.tck_prev;
  assign tms      = pin_q.tms_sync[1];
  // Unused test reset pin reads as one; a pulse shorter than one clock can be missed
  assign trst_n   = TEST_RESET_USED ? pin_q.trst_sync[1] : 1'b1;

  // Switch sequence detector and boundary-scan TAP, power-on reset domain only
  always_comb
  begin
    port_d = port_q;
    if (tck_rise)
    begin
      case (port_q.seq)
        dbg_select_pkg::SEQ_IDLE,
        dbg_select_pkg::SEQ_LEAD:
        begin
          if (tms)
          begin
            if (port_q.high_cnt != `HIGH_RUN_MIN)
              port_d.high_cnt = port_q.high_cnt + 7'd1;
            // The fiftieth high already completes the run, the probe may stop there
            port_d.seq = (port_q.high_cnt >= `HIGH_RUN_MIN - 7'd1) ?
                         dbg_select_pkg::SEQ_LEAD : dbg_select_pkg::SEQ_IDLE;
          end
          else if (port_q.seq == dbg_select_pkg::SEQ_LEAD)
          begin
            // First zero of the code ends the lead-in; code bits shift in LSB first
            port_d.seq      = dbg_select_pkg::SEQ_CODE;
            port_d.shift    = {1'b0, 15'h0000};
            port_d.bit_cnt  = 4'd1;
            port_d.high_cnt = 7'd0;
          end
          else
            port_d.high_cnt = 7'd0;
        end
        dbg_select_pkg::SEQ_CODE:
        begin
          port_d.shift   = {tms, port_q.shift[15:1]};
          port_d.bit_cnt = port_q.bit_cnt + 4'd1;
          if (port_q.bit_cnt == 4'd15)
          begin
            // Both codes begin with a zero, so the zero that ended the run is bit 0
            if ({tms, port_q.shift[15:1]} == `TO_SWD_CODE ||
                {tms, port_q.shift[15:1]} == `TO_JTAG_CODE)
              port_d.seq = dbg_select_pkg::SEQ_TAIL;
            else
              port_d.seq = dbg_select_pkg::SEQ_IDLE;
          end
        end
        dbg_select_pkg::SEQ_TAIL:
        begin
          if (!tms)
          begin
            port_d.seq      = dbg_select_pkg::SEQ_IDLE;
            port_d.high_cnt = 7'd0;
          end
          else if (port_q.high_cnt == `HIGH_RUN_MIN - 7'd1)
          begin
            if (port_q.shift == `TO_SWD_CODE)
              port_d.swd_mode = 1'b1;
            else if (port_q.shift == `TO_JTAG_CODE)
              port_d.swd_mode = 1'b0;
            port_d.seq      = dbg_select_pkg::SEQ_LEAD;
            port_d.high_cnt = `HIGH_RUN_MIN;
          end
          else
            port_d.high_cnt = port_q.high_cnt + 7'd1;
        end
        default:
          port_d.seq = dbg_select_pkg::SEQ_IDLE;
      endcase
    end

    // Boundary-scan TAP, active only in JTAG mode
    if (!trst_n)
    begin
      port_d.tap = dbg_select_pkg::TAP_RESET;
      port_d.ir  = `BSCAN_IR_IDCODE;
    end
    else if (tck_rise && !port_q.swd_mode)
    begin
      case (port_q.tap)
        dbg_select_pkg::TAP_RESET:
        begin
          port_d.ir  = `BSCAN_IR_IDCODE;
          port_d.tap = tms ? dbg_select_pkg::TAP_RESET : dbg_select_pkg::TAP_IDLE;
        end
        dbg_select_pkg::TAP_IDLE:
          port_d.tap = tms ? dbg_select_pkg::TAP_SEL_DR : dbg_select_pkg::TAP_IDLE;
        dbg_select_pkg::TAP_SEL_DR:
          port_d.tap = tms ? dbg_select_pkg::TAP_SEL_IR : dbg_select_pkg::TAP_CAP_DR;
        dbg_select_pkg::TAP_CAP_DR:
        begin
          port_d.dr_shift = (port_q.ir == `BSCAN_IR_IDCODE) ? `BSCAN_IDCODE : 32'h0000_0000;
          port_d.tap = tms ? dbg_select_pkg::TAP_EX1_DR : dbg_select_pkg::TAP_SH_DR;
        end
        dbg_select_pkg::TAP_SH_DR:
        begin
          // bypass is a single stage behind the core TAP
          if (port_q.ir == `BSCAN_IR_IDCODE)
            port_d.dr_shift = {CORE_TAP_TDO, port_q.dr_shift[31:1]};
          else
            port_d.dr_shift = {31'h0000_0000, CORE_TAP_TDO};
          port_d.tap = tms ? dbg_select_pkg::TAP_EX1_DR : dbg_select_pkg::TAP_SH_DR;
        end
        dbg_select_pkg::TAP_EX1_DR:
          port_d.tap = tms ? dbg_select_pkg::TAP_UPD_DR : dbg_select_pkg::TAP_PAUSE_DR;
        dbg_select_pkg::TAP_PAUSE_DR:
          port_d.tap = tms ? dbg_select_pkg::TAP_EX2_DR : dbg_select_pkg::TAP_PAUSE_DR;
        dbg_select_pkg::TAP_EX2_DR:
          port_d.tap = tms ? dbg_select_pkg::TAP_UPD_DR : dbg_select_pkg::TAP_SH_DR;
        dbg_select_pkg::TAP_UPD_DR:
          port_d.tap = tms ? dbg_select_pkg::TAP_SEL_DR : dbg_select_pkg::TAP_IDLE;
        dbg_select_pkg::TAP_UPD_IR:
        begin
          // Instruction changes only on update or in test logic reset, so a pause inside the shift is harmless
          port_d.ir  = port_q.ir_shift;
          port_d.tap = tms ? dbg_select_pkg::TAP_SEL_DR : dbg_select_pkg::TAP_IDLE;
        end
        dbg_select_pkg::TAP_SEL_IR:
          port_d.tap = tms ? dbg_select_pkg::TAP_RESET : dbg_select_pkg::TAP_CAP_IR;
        dbg_select_pkg::TAP_CAP_IR:
        begin
          port_d.ir_shift = 5'h01;
          port_d.tap = tms ? dbg_select_pkg::TAP_EX1_IR : dbg_select_pkg::TAP_SH_IR;
        end
        dbg_select_pkg::TAP_SH_IR:
        begin
          // boundary IR sits nearest the data out pin, so its 5 bits go in first
          port_d.ir_shift = {CORE_TAP_TDO, port_q.ir_shift[4:1]};
          port_d.tap = tms ? dbg_select_pkg::TAP_EX1_IR : dbg_select_pkg::TAP_SH_IR;
        end
        dbg_select_pkg::TAP_EX1_IR:
          port_d.tap = tms ? dbg_select_pkg::TAP_UPD_IR : dbg_select_pkg::TAP_PAUSE_IR;
        dbg_select_pkg::TAP_PAUSE_IR:
          port_d.tap = tms ? dbg_select_pkg::TAP_EX2_IR : dbg_select_pkg::TAP_PAUSE_IR;
        dbg_select_pkg::TAP_EX2_IR:
          port_d.tap = tms ? dbg_select_pkg::TAP_UPD_IR : dbg_select_pkg::TAP_SH_IR;
        default:
          port_d.tap = dbg_select_pkg::TAP_RESET;
      endcase
    end

    // Data out changes on the falling test clock edge
    if (tck_fall)
    begin
      port_d.tdo_en = (port_q.tap == dbg_select_pkg::TAP_SH_DR) ||
                      (port_q.tap == dbg_select_pkg::TAP_SH_IR);
      port_d.tdo    = (port_q.tap == dbg_select_pkg::TAP_SH_IR) ? port_q.ir_shift[0] :
                      port_q.dr_shift[0];
    end
  end

  // power-on reset only; JTAG after reset
  always_ff @(posedge CLK_SYS or negedge POR_N)
  begin
    if (!POR_N)
    begin
      port_q          <= '0;
      port_q.seq      <= dbg_select_pkg::SEQ_IDLE;
      port_q.tap      <= dbg_select_pkg::TAP_RESET;
      port_q.ir       <= `BSCAN_IR_IDCODE;
      port_q.swd_mode <= 1'b0;
    end
    else if (CE)
      port_q <= port_d;
  end

  // APB slave: zero wait states, error on unmapped or write to the ID word
  // Read data is latched in the setup cycle so it stands through the access cycle
  assign addr_ok = (PADDR == `ADDR_ID_CODE) || (PADDR == `ADDR_DEBUG_CONTROL);
  assign wr_en   = PSEL & PENABLE & PWRITE & (PADDR == `ADDR_DEBUG_CONTROL);
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & (~addr_ok | (PWRITE & (PADDR == `ADDR_ID_CODE)));

  always_comb
  begin
    por_d = por_q;
    if (wr_en)
      por_d.debug_control_reg = PWDATA & `DEBUG_CONTROL_MASK;
  end

  // power reset only, system reset leaves it
  always_ff @(posedge CLK_SYS or negedge POR_N)
  begin
    if (!POR_N)
      por_q.debug_control_reg <= `DEBUG_CONTROL_RESET;
    else if (CE)
      por_q <= por_d;
  end

  always_comb
  begin
    sys_d = sys_q;
    if (rd_en)
      sys_d.prdata = (PADDR == `ADDR_ID_CODE)       ? `ID_CODE_VALUE :
                     (PADDR == `ADDR_DEBUG_CONTROL) ? por_q.debug_control_reg  : 32'h0000_0000;
    // halt latched during system reset, held from the first cycle after
    // A dropped request ends it, so a later ordinary halt is not held
    if (SYS_RESET_ACTIVE)
      sys_d.halt_pending = HALT_REQUEST;
    else if (!HALT_REQUEST)
      sys_d.halt_pending = 1'b0;
    sys_d.halt_hold = sys_q.halt_pending & ~SYS_RESET_ACTIVE & HALT_REQUEST;
  end

  // RESETN is the system reset: it leaves debug state alone
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      sys_q <= '0;
    else if (CE)
      sys_q <= sys_d;
  end

  assign PRDATA         = sys_q.prdata;
  // The pending flag covers the first cycle after release, before halt_hold is registered
  assign CORE_HALT_HOLD = (HALT_REQUEST & (SYS_RESET_ACTIVE | sys_q.halt_pending)) |
                          sys_q.halt_hold;

  // Pin sharing and release
  assign SWD_ACTIVE       = port_q.swd_mode;
  assign JTAG_ACTIVE      = ~port_q.swd_mode;
  assign SWDIO_IN         = tms;
  assign SWCLK_IN         = pin_q.tck_sync[1];
  assign TAP_RESET_N      = trst_n;
  // Data in always feeds the core TAP first; the boundary stage follows it
  assign CORE_TAP_TDI     = pin_q.tdi_sync[1];
  assign RELEASE_TDI_PIN  = port_q.swd_mode;
  // Trace keeps the data out pin even in serial wire mode
  assign RELEASE_TDO_PIN  = port_q.swd_mode & ~por_q.debug_control_reg[`BIT_TRACE_EN];
  assign RELEASE_TRST_PIN = port_q.swd_mode | ~TEST_RESET_USED;
  assign TEST_DATA_OUT_PIN = por_q.debug_control_reg[`BIT_TRACE_EN] ? ASYNC_TRACE_DATA : port_q.tdo;
  assign TEST_DATA_OUT_OE  = por_q.debug_control_reg[`BIT_TRACE_EN] |
                             (~port_q.swd_mode & port_q.tdo_en);

  // Power mode clock keeps
  assign AHB_CLK_KEEP = (IN_SLEEP & por_q.debug_control_reg[`BIT_SLP_KEEP]) |
                        (IN_DEEP_SLEEP & por_q.debug_control_reg[`BIT_DSLP_KEEP]) |
                        (IN_STANDBY & por_q.debug_control_reg[`BIT_STB_KEEP]);
  assign SYS_CLK_FROM_RC = (IN_DEEP_SLEEP & por_q.debug_control_reg[`BIT_DSLP_KEEP]) |
                           (IN_STANDBY & por_q.debug_control_reg[`BIT_STB_KEEP]);
  assign STANDBY_EXIT_RESET = STANDBY_EXIT;

  // Hold controls while halted, and the ROM ID select decode
  assign halted = CORE_HALTED;
  assign TIMER_FREEZE = {14{halted}} & {por_q.debug_control_reg[30:25], por_q.debug_control_reg[20:17],
                                        por_q.debug_control_reg[13:10]};
  assign SMBUS_TIMEOUT_FREEZE = {2{halted}} &
                                {por_q.debug_control_reg[`BIT_I2C1_FREEZE],
                                 por_q.debug_control_reg[`BIT_I2C0_FREEZE]};
  assign WINDOW_WATCHDOG_GATE = halted & por_q.debug_control_reg[`BIT_WWDG_FREEZE];
  assign FREE_WATCHDOG_GATE   = halted & por_q.debug_control_reg[`BIT_FWDG_FREEZE];
  assign ROM_ID_SELECT = (ROM_ADDR >= `ROM_BASE) && (ROM_ADDR <= `ROM_LAST);
endmodule

// file: testbench/debug_port_select_and_hold_asserts.sv
// Concurrent checks for the debug port select and hold unit.
// Assumes binding into the top module; watches its ports only.
module debug_port_select_and_hold_asserts (
  // Clock and resets
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        POR_N,
  // Probe pins and port mode
  input wire logic        TEST_CLOCK_PIN,
  input wire logic        TEST_MODE_SELECT_PIN,
  input wire logic        TEST_RESET_N_PIN,
  input wire logic        TEST_RESET_USED,
  input wire logic        SWD_ACTIVE,
  input wire logic        JTAG_ACTIVE,
  input wire logic        SWDIO_IN,
  input wire logic        SWCLK_IN,
  input wire logic        TAP_RESET_N,
  input wire logic        RELEASE_TDI_PIN,
  input wire logic        RELEASE_TRST_PIN,
  // Halt and hold
  input wire logic        SYS_RESET_ACTIVE,
  input wire logic        HALT_REQUEST,
  input wire logic        CORE_HALT_HOLD,
  input wire logic        CORE_HALTED,
  input wire logic [13:0] TIMER_FREEZE,
  input wire logic [1:0]  SMBUS_TIMEOUT_FREEZE,
  input wire logic        WINDOW_WATCHDOG_GATE,
  input wire logic        FREE_WATCHDOG_GATE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  sequence s_halt_in_reset;
    SYS_RESET_ACTIVE && HALT_REQUEST;
  endsequence
  sequence s_released_with_halt;
    !SYS_RESET_ACTIVE && HALT_REQUEST;
  endsequence
  property p_por_jtag;
    disable iff (!POR_N) $rose(POR_N) |-> JTAG_ACTIVE && !SWD_ACTIVE;
  endproperty
  a_por_jtag: assert property (p_por_jtag) else $error("jtag not active after power-on");
  property p_one_port;
    disable iff (!POR_N) SWD_ACTIVE != JTAG_ACTIVE;
  endproperty
  a_one_port: assert property (p_one_port) else $error("port mode flags disagree");
  // Mode may only flip right after a sampled rising test clock with mode select high
  property p_switch_edge;
    disable iff (!POR_N) $changed(SWD_ACTIVE) |->
      $past(TEST_CLOCK_PIN, 2) && $past(TEST_MODE_SELECT_PIN, 2);
  endproperty
  a_switch_edge: assert property (p_switch_edge)
    else $error("mode flip off a tail bit");
  property p_pin_share;
    disable iff (!POR_N) ($stable(TEST_CLOCK_PIN) && $stable(TEST_MODE_SELECT_PIN)) [*6]
      |-> SWCLK_IN == TEST_CLOCK_PIN && SWDIO_IN == TEST_MODE_SELECT_PIN;
  endproperty
  a_pin_share: assert property (p_pin_share)
    else $error("serial wire copies differ from pins");
  property p_tied_reset;
    disable iff (!POR_N) !TEST_RESET_USED [*3] |-> TAP_RESET_N;
  endproperty
  a_tied_reset: assert property (p_tied_reset) else $error("unused test reset not inactive");
  property p_tap_reset_only;
    disable iff (!POR_N) (TEST_RESET_USED && !TEST_RESET_N_PIN) [*4]
      |-> !TAP_RESET_N && $stable(SWD_ACTIVE);
  endproperty
  a_tap_reset_only: assert property (p_tap_reset_only) else $error("test reset misbehaves");
  property p_swd_release;
    disable iff (!POR_N) SWD_ACTIVE [*2] |-> RELEASE_TDI_PIN && RELEASE_TRST_PIN;
  endproperty
  a_swd_release: assert property (p_swd_release)
    else $error("pins kept in serial wire mode");
  property p_halt_after_reset;
    disable iff (!RESETN) s_halt_in_reset ##1 s_released_with_halt |-> CORE_HALT_HOLD;
  endproperty
  a_halt_after_reset: assert property (p_halt_after_reset)
    else $error("core not held halted");
  property p_no_freeze_running;
    disable iff (!POR_N) !CORE_HALTED |-> TIMER_FREEZE == 14'h0000 && SMBUS_TIMEOUT_FREEZE == 2'h0
      && !WINDOW_WATCHDOG_GATE && !FREE_WATCHDOG_GATE;
  endproperty
  a_no_freeze_running: assert property (p_no_freeze_running)
    else $error("hold while running");
endmodule

bind debug_port_select_and_hold debug_port_select_and_hold_asserts i_asserts (
  .CLK_SYS, .RESETN, .POR_N, .TEST_CLOCK_PIN, .TEST_MODE_SELECT_PIN, .TEST_RESET_N_PIN,
  .TEST_RESET_USED, .SWD_ACTIVE, .JTAG_ACTIVE, .SWDIO_IN, .SWCLK_IN, .TAP_RESET_N,
  .RELEASE_TDI_PIN, .RELEASE_TRST_PIN, .SYS_RESET_ACTIVE, .HALT_REQUEST, .CORE_HALT_HOLD,
  .CORE_HALTED, .TIMER_FREEZE, .SMBUS_TIMEOUT_FREEZE, .WINDOW_WATCHDOG_GATE, .FREE_WATCHDOG_GATE
);

// file: testbench/debug_port_select_and_hold_tb.sv
// Self-checking bench for the debug port select and hold unit.
// Assumes the probe model on the pins and a zero-length core TAP.
`include "dbg_select_consts.svh"
module debug_port_select_and_hold_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS, CE, RESETN, POR_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, ROM_ADDR, rdat, dout;
  logic        TEST_CLOCK_PIN, TEST_MODE_SELECT_PIN, TEST_DATA_IN_PIN, TEST_RESET_N_PIN;
  logic        TEST_RESET_USED, TEST_DATA_OUT_PIN, TEST_DATA_OUT_OE, ASYNC_TRACE_DATA;
  logic        CORE_TAP_TDO, CORE_TAP_TDI, SWD_ACTIVE, JTAG_ACTIVE, TAP_RESET_N;
  logic        SYS_RESET_ACTIVE, HALT_REQUEST, CORE_HALTED, CORE_HALT_HOLD, ROM_ID_SELECT;
  logic        RELEASE_TDI_PIN, RELEASE_TDO_PIN, RELEASE_TRST_PIN, err;
  logic        IN_SLEEP, IN_DEEP_SLEEP, IN_STANDBY, STANDBY_EXIT;
  logic        AHB_CLK_KEEP, SYS_CLK_FROM_RC, STANDBY_EXIT_RESET;
  logic        WINDOW_WATCHDOG_GATE, FREE_WATCHDOG_GATE;
  logic [13:0] TIMER_FREEZE;
  logic [1:0]  SMBUS_TIMEOUT_FREEZE;
  int          n_errors, total_checks;
  logic [31:0] rom_a [4] = '{32'hE00F_EFFF, 32'hE00F_F000, 32'hE00F_FFFF, 32'hE010_0000};
  // Core TAP stand-in is a plain wire, so any extra bit comes from the device
  assign CORE_TAP_TDO = CORE_TAP_TDI;
  debug_port_select_and_hold i_dut (
    .CLK_SYS, .CE, .RESETN, .POR_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .TEST_CLOCK_PIN, .TEST_MODE_SELECT_PIN, .TEST_DATA_IN_PIN,
    .TEST_RESET_N_PIN, .TEST_RESET_USED, .TEST_DATA_OUT_PIN, .TEST_DATA_OUT_OE,
    .ASYNC_TRACE_DATA, .CORE_TAP_TDO, .CORE_TAP_TDI, .SWD_ACTIVE, .JTAG_ACTIVE,
    .SWDIO_IN(), .SWCLK_IN(), .TAP_RESET_N, .SYS_RESET_ACTIVE, .HALT_REQUEST, .CORE_HALTED,
    .CORE_HALT_HOLD, .RELEASE_TDI_PIN, .RELEASE_TDO_PIN, .RELEASE_TRST_PIN, .IN_SLEEP,
    .IN_DEEP_SLEEP, .IN_STANDBY, .STANDBY_EXIT, .AHB_CLK_KEEP, .SYS_CLK_FROM_RC,
    .STANDBY_EXIT_RESET, .TIMER_FREEZE, .SMBUS_TIMEOUT_FREEZE, .WINDOW_WATCHDOG_GATE,
    .FREE_WATCHDOG_GATE, .ROM_ID_SELECT, .ROM_ADDR
  );
  probe_model i_probe (
    .tck(TEST_CLOCK_PIN), .tms(TEST_MODE_SELECT_PIN), .tdi(TEST_DATA_IN_PIN),
    .tdo(TEST_DATA_OUT_PIN), .tdo_oe(TEST_DATA_OUT_OE)
  );
  initial
  begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge CLK_SYS);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= a;
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1)
      @(posedge CLK_SYS);
    rdat = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // Leave the caller off the clock edge so probe pins never move on it
    #1;
  endtask
  // Each nibble of exp holds keep, from-rc and exit-reset for sleep, deep, standby, exit
  task automatic modes(input logic [15:0] exp);
    for (int m = 0; m < 4; m++)
    begin
      {IN_SLEEP, IN_DEEP_SLEEP, IN_STANDBY, STANDBY_EXIT} <= 4'h8 >> m;
      tick(2);
      cmp32({AHB_CLK_KEEP, SYS_CLK_FROM_RC, STANDBY_EXIT_RESET}, exp[m*4+:3]);
    end
    {IN_SLEEP, IN_DEEP_SLEEP, IN_STANDBY, STANDBY_EXIT} <= 4'h0;
  endtask
  initial
  begin
    #1_000_000;
    n_errors++;
    close_out();
  end
  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, ROM_ADDR, ASYNC_TRACE_DATA} = '0;
    {SYS_RESET_ACTIVE, HALT_REQUEST, CORE_HALTED, IN_SLEEP, IN_DEEP_SLEEP} = '0;
    {IN_STANDBY, STANDBY_EXIT, RESETN, POR_N} = '0;
    {CE, TEST_RESET_N_PIN, TEST_RESET_USED} = 3'h7;
    repeat (10) @(posedge CLK_SYS);
    POR_N  <= 1'b1;
    RESETN <= 1'b1;
    tick(2);
    cmp32({SWD_ACTIVE, JTAG_ACTIVE, RELEASE_TDI_PIN, RELEASE_TDO_PIN}, 32'h4);
    apb(1'b0, `ADDR_DEBUG_CONTROL, 32'h0);
    cmp32(rdat, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0);
    cmp32(err, 32'h1);
    apb(1'b1, `ADDR_ID_CODE, 32'h0);
    cmp32(err, 32'h1);
    apb(1'b0, `ADDR_ID_CODE, 32'h0);
    cmp32(rdat, `ID_CODE_VALUE);
    i_probe.walk(8'h02, 4);
    i_probe.scan(32, 32'h0, dout);
    cmp32(dout, `BSCAN_IDCODE);
    i_probe.walk(8'h07, 5);
    i_probe.scan(9, 32'h1FF, dout);
    cmp32(dout, 32'h1E1);
    i_probe.walk(8'h03, 4);
    i_probe.scan(9, 32'hB4, dout);
    cmp32(dout[8:1], 32'hB4);
    i_probe.walk(8'h01, 2);
    apb(1'b1, `ADDR_DEBUG_CONTROL, 32'hFFFF_FFFF);
    apb(1'b0, `ADDR_DEBUG_CONTROL, 32'h0);
    cmp32(rdat, `DEBUG_CONTROL_MASK);
    CORE_HALTED <= 1'b1;
    ASYNC_TRACE_DATA <= 1'b1;
    tick(2);
    cmp32(TIMER_FREEZE, 32'h3FFF);
    cmp32({SMBUS_TIMEOUT_FREEZE, WINDOW_WATCHDOG_GATE, FREE_WATCHDOG_GATE}, 32'hF);
    cmp32({TEST_DATA_OUT_PIN, TEST_DATA_OUT_OE}, 32'h3);
    ASYNC_TRACE_DATA <= 1'b0;
    tick(2);
    cmp32({TEST_DATA_OUT_PIN, TEST_DATA_OUT_OE}, 32'h1);
    modes(16'h1664);
    RESETN <= 1'b0;
    tick(3);
    RESETN <= 1'b1;
    apb(1'b0, `ADDR_DEBUG_CONTROL, 32'h0);
    cmp32(rdat, `DEBUG_CONTROL_MASK);
    apb(1'b1, `ADDR_DEBUG_CONTROL, 32'h0);
    tick(1);
    cmp32({TIMER_FREEZE, SMBUS_TIMEOUT_FREEZE}, 32'h0);
    modes(16'h1000);
    CORE_HALTED <= 1'b0;
    SYS_RESET_ACTIVE <= 1'b1;
    HALT_REQUEST <= 1'b1;
    tick(2);
    SYS_RESET_ACTIVE <= 1'b0;
    tick(1);
    cmp32(CORE_HALT_HOLD, 32'h1);
    HALT_REQUEST <= 1'b0;
    TEST_RESET_N_PIN <= 1'b0;
    tick(5);
    cmp32({TAP_RESET_N, JTAG_ACTIVE}, 32'h1);
    TEST_RESET_USED <= 1'b0;
    tick(5);
    cmp32(TAP_RESET_N, 32'h1);
    TEST_RESET_N_PIN <= 1'b1;
    TEST_RESET_USED <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ROM_ADDR <= rom_a[i];
      tick(1);
      cmp32(ROM_ID_SELECT, i == 1 || i == 2);
    end
    i_probe.switch_seq(`TO_SWD_CODE, 50);
    tick(2);
    cmp32({SWD_ACTIVE, JTAG_ACTIVE}, 32'h2);
    cmp32({RELEASE_TDI_PIN, RELEASE_TDO_PIN, RELEASE_TRST_PIN}, 32'h7);
    i_probe.switch_seq(`TO_JTAG_CODE, 20);
    i_probe.walk(8'h00, 1);
    i_probe.switch_seq(16'hE73D, 50);
    tick(2);
    cmp32(SWD_ACTIVE, 32'h1);
    i_probe.switch_seq(`TO_JTAG_CODE, 50);
    tick(2);
    cmp32({SWD_ACTIVE, JTAG_ACTIVE, RELEASE_TDI_PIN}, 32'h2);
    apb(1'b1, `ADDR_DEBUG_CONTROL, 32'h0000_0001);
    apb(1'b0, `ADDR_DEBUG_CONTROL, 32'h0);
    cmp32(rdat, 32'h0000_0001);
    POR_N <= 1'b0;
    tick(2);
    POR_N <= 1'b1;
    apb(1'b0, `ADDR_DEBUG_CONTROL, 32'h0);
    cmp32(rdat, 32'h0000_0000);
    close_out();
  end
endmodule

// file: testbench/probe_model.sv
// Debug probe model driving test clock, mode select and data in.
// Assumes the test clock stands low between frames and runs at 320 ns inside.
module probe_model (
  // Pins toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  // Data out pin and its enable
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    last_q = 1'b0;
  end
  // A released data out line floats, so show the inverse of the last bit seen
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160;
    tck = 1'b1;
    q = tdo_oe ? tdo : ~last_q;
    last_q = q;
    #160;
    tck = 1'b0;
  endtask
  task automatic walk(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      cyc(path[i], 1'b0, q);
  endtask
  task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0000_0000;
    for (int i = 0; i < n; i++)
      cyc(i == n - 1, din[i], dout[i]);
  endtask
  task automatic switch_seq(input logic [15:0] code, input int tail);
    logic q;
    for (int i = 0; i < 66 + tail; i++)
      cyc(i < 50 || i >= 66 || code[i - 50], 1'b0, q);
  endtask
endmodule
